//--- rtu_return_unit.sv
// return instruction unit: decodes and executes the three stack return instructions
`timescale 1ns/1ps
`default_nettype none
module rtu_return_unit (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // fetch path
  input wire rtu_pkg::rtu_fetch_type fetch_in,
  // return stack top
  input wire logic [12:0] stack_top_entry_in,
  // software writes to irq control, from the core
  input wire logic irqcon_wr_in,
  input wire logic [7:0] irqcon_wdata_in,
  // core control
  output rtu_pkg::rtu_ctl_type ctl_out,
  output logic busy_out,
  // architectural state
  output logic [7:0] wreg_out,
  output logic [7:0] irq_control_reg_out,
  output logic [12:0] pc_out,
  output logic global_irq_enable_out
);
  typedef enum logic [1:0] {
    RTU_ST_EXEC = 2'b01,
    RTU_ST_FLUSH = 2'b10
  } rtu_state_type;

  rtu_state_type state_reg;
  rtu_state_type state_next;
  rtu_pkg::rtu_kind_type kind;
  logic [7:0] literal;
  logic [7:0] wreg_reg;
  logic [7:0] irqcon_reg;
  logic [12:0] pc_reg;
  logic pop_reg;

  rtu_decode u_decode (
    .word_in(fetch_in.word),
    .kind_out(kind),
    .literal_out(literal)
  );

  // a word arriving while flushing is the stale prefetch and is ignored
  wire in_exec = (state_reg == RTU_ST_EXEC);
  wire take = in_exec && fetch_in.valid && (kind != rtu_pkg::RTU_KIND_NONE);
  wire take_irq = take && (kind == rtu_pkg::RTU_KIND_IRQ);
  wire take_lit = take && (kind == rtu_pkg::RTU_KIND_LIT);

  // cycle 1 takes the return, cycle 2 drives pop, pc load and flush together
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RTU_ST_EXEC: begin
        if (take) begin
          state_next = RTU_ST_FLUSH;
        end
      end
      RTU_ST_FLUSH: begin
        state_next = RTU_ST_EXEC;
      end
      default: begin
        state_next = RTU_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg <= RTU_ST_EXEC;
    end else begin
      state_reg <= state_next;
    end
  end

  // pc takes the stack top on any return
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pc_reg <= rtu_pkg::PC_RESET;
      pop_reg <= 1'b0;
    end else begin
      pop_reg <= take;
      if (take) begin
        pc_reg <= stack_top_entry_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wreg_reg <= rtu_pkg::WREG_RESET;
    end else if (take_lit) begin
      wreg_reg <= literal;
    end
  end

  // the return's set beats a same-cycle software write to the enable bit
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irqcon_reg <= rtu_pkg::IRQCON_RESET;
    end else begin
      if (irqcon_wr_in) begin
        irqcon_reg <= irqcon_wdata_in;
      end
      if (take_irq) begin
        irqcon_reg[rtu_pkg::GIE_BIT] <= 1'b1;
      end
    end
  end

  // no status flag output exists, so status is untouched by design
  // one driver for the whole struct, fields named so the packing order cannot slip
  wire in_flush = (state_reg == RTU_ST_FLUSH);
  assign ctl_out = '{
    pc_load: pop_reg,
    pc_value: pc_reg,
    stack_pop: pop_reg,
    flush: in_flush
  };
  assign busy_out = (state_reg == RTU_ST_FLUSH);
  assign wreg_out = wreg_reg;
  assign irq_control_reg_out = irqcon_reg;
  assign pc_out = pc_reg;
  assign global_irq_enable_out = irqcon_reg[rtu_pkg::GIE_BIT];
endmodule : rtu_return_unit
`default_nettype wire

//--- rtu_pkg.sv
// package: encodings, widths and timing constants of the return instruction unit
package rtu_pkg;
  localparam int INSN_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam logic [13:0] ENC_SUB_RETURN = 14'h0008;
  localparam logic [13:0] ENC_IRQ_RETURN = 14'h0009;
  localparam logic [13:0] ENC_LIT_MASK = 14'h3c00;
  localparam logic [13:0] ENC_LIT_MATCH = 14'h3400;
  localparam int GIE_BIT = 7;
  localparam int RETURN_CYCLES = 2;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic [7:0] IRQCON_RESET = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;

  typedef enum logic [1:0] {
    RTU_KIND_NONE = 2'h0,
    RTU_KIND_SUB = 2'h1,
    RTU_KIND_IRQ = 2'h2,
    RTU_KIND_LIT = 2'h3
  } rtu_kind_type;

  // fetch path to decoder
  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } rtu_fetch_type;

  // update commands toward the core
  typedef struct packed {
    logic pc_load;
    logic [12:0] pc_value;
    logic stack_pop;
    logic flush;
  } rtu_ctl_type;
endpackage : rtu_pkg

//--- rtu_decode.sv
// decoder that classifies a fetched word as one of the three return instructions or as none
`timescale 1ns/1ps
`default_nettype none
module rtu_decode (
  // instruction word
  input wire logic [13:0] word_in,
  // classification
  output rtu_pkg::rtu_kind_type kind_out,
  output logic [7:0] literal_out
);
  wire is_sub = (word_in == rtu_pkg::ENC_SUB_RETURN);
  wire is_irq = (word_in == rtu_pkg::ENC_IRQ_RETURN);
  // bits 9 and 8 are masked off, so all four variants decode alike
  wire is_lit = ((word_in & rtu_pkg::ENC_LIT_MASK) == rtu_pkg::ENC_LIT_MATCH);

  assign kind_out = is_irq ? rtu_pkg::RTU_KIND_IRQ :
                    is_sub ? rtu_pkg::RTU_KIND_SUB :
                    is_lit ? rtu_pkg::RTU_KIND_LIT : rtu_pkg::RTU_KIND_NONE;
  assign literal_out = word_in[7:0];
endmodule : rtu_decode
`default_nettype wire

//--- rtu_return_unit_asserts.sv
// assertion checker for the return instruction unit
`timescale 1ns/1ps
`default_nettype none
module rtu_chk (
  input wire logic clk_in, sys_rst_in, irqcon_wr_in, busy_out, global_irq_enable_out,
  input wire rtu_pkg::rtu_fetch_type fetch_in,
  input wire logic [12:0] stack_top_entry_in, pc_out,
  input wire logic [7:0] irqcon_wdata_in, wreg_out, irq_control_reg_out,
  input wire rtu_pkg::rtu_ctl_type ctl_out
);
  wire go = fetch_in.valid && !busy_out;
  wire sub = go && fetch_in.word == rtu_pkg::ENC_SUB_RETURN;
  wire irq = go && fetch_in.word == rtu_pkg::ENC_IRQ_RETURN;
  wire lit = go && (fetch_in.word & rtu_pkg::ENC_LIT_MASK) == rtu_pkg::ENC_LIT_MATCH;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_pop_pc: assert property ((sub || irq || lit) |=>
    ctl_out.stack_pop && pc_out == $past(stack_top_entry_in)) else $error("bad pop");
  a_irq_gie: assert property (irq |=> global_irq_enable_out) else $error("bad gie");
  a_gie_bit: assert property (global_irq_enable_out == irq_control_reg_out[7])
    else $error("gie not bit 7");
  a_two_cyc: assert property ((sub || irq || lit) |=>
    busy_out ##1 !busy_out) else $error("bad length");
  a_lit_wreg: assert property (lit |=> wreg_out == $past(fetch_in.word[7:0]))
    else $error("bad literal");
  a_flush_hold: assert property (busy_out |=> $stable(wreg_out) && $stable(pc_out))
    else $error("flush word ran");
  a_sub_gie: assert property (sub && !irqcon_wr_in |=> $stable(irq_control_reg_out))
    else $error("sub return touched enable");
  a_pop_once: assert property (ctl_out.stack_pop |=> !ctl_out.stack_pop)
    else $error("pop too long");
  a_pc_value: assert property (ctl_out.pc_load |-> ctl_out.pc_value == pc_out)
    else $error("pc value differs");
  a_irqcon_write: assert property (irqcon_wr_in |=>
    irq_control_reg_out[6:0] == $past(irqcon_wdata_in[6:0])) else $error("bad irq write");
  c_sub: cover property (sub);
  c_irq: cover property (irq);
  c_lit: cover property (lit);
endmodule : rtu_chk
bind rtu_return_unit rtu_chk u_chk (.*);
`default_nettype wire

//--- rtu_core_model.sv
// return stack model standing in for the core
`timescale 1ns/1ps
`default_nettype none
module rtu_core_model (
  input wire logic clk_in,
  input wire logic pop_in,
  output logic [12:0] top_out
);
  logic [7:0] depth_reg = 8'h00;
  // shows the entry left after a pop in flight, so a back to back return sees it
  wire [7:0] depth_next = depth_reg + {7'h00, pop_in};
  assign top_out = {depth_next[4:0], ~depth_next};
  always_ff @(posedge clk_in) depth_reg <= depth_next;
endmodule : rtu_core_model
`default_nettype wire

//--- test_return_instruction_unit.sv
// testbench for the return instruction unit
`timescale 1ns/1ps
`default_nettype none
module test_return_instruction_unit;
  logic clk_in = 0, sys_rst_in = 1, irqcon_wr_in = 0, busy_out, global_irq_enable_out, g = 0;
  logic [7:0] irqcon_wdata_in = 8'h00, wreg_out, irq_control_reg_out, w = 8'h00;
  logic [12:0] top, pc_out;
  rtu_pkg::rtu_fetch_type fetch_in = '0;
  rtu_pkg::rtu_ctl_type ctl_out;
  logic [21:0] q[$];
  logic [31:0] r;
  int fail_count = 0, n_checks = 0, cyc = 0;
  always #25 clk_in = ~clk_in;
  rtu_return_unit dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .fetch_in(fetch_in),
    .stack_top_entry_in(top), .irqcon_wr_in(irqcon_wr_in), .irqcon_wdata_in(irqcon_wdata_in),
    .ctl_out(ctl_out), .busy_out(busy_out), .wreg_out(wreg_out),
    .irq_control_reg_out(irq_control_reg_out), .pc_out(pc_out),
    .global_irq_enable_out(global_irq_enable_out));
  rtu_core_model core (.clk_in(clk_in), .pop_in(ctl_out.stack_pop), .top_out(top));
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 500) begin
      fail_count++;
      give_verdict;
    end else if (ctl_out.pc_load === 1'b1) begin
      n_checks++;
      if ({pc_out, wreg_out, global_irq_enable_out} !== q[0]) begin
        $display("BAD return state exp %h got %h", q[0], {pc_out, wreg_out, global_irq_enable_out});
        fail_count++;
      end
      void'(q.pop_front());
    end
  end
  initial begin
    r = $urandom(32'h84ef1987);
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (24) begin
      @(posedge clk_in);
      r = $urandom;
      fetch_in <= {1'b1, r[3] ? (14'h3400 | {4'h0, r[13:4]}) : {13'h0004, r[2]}};
      irqcon_wr_in <= r[30];
      irqcon_wdata_in <= r[27:20];
      w = r[3] ? r[11:4] : w;
      g = (!r[3] && r[2]) ? 1'b1 : (r[30] ? r[27] : g);
      q.push_back({top, w, g});
      @(posedge clk_in);
      // an interrupt return offered in the flush cycle must be dropped
      fetch_in.word <= rtu_pkg::ENC_IRQ_RETURN;
      irqcon_wr_in <= 1'b0;
    end
    @(posedge clk_in);
    fetch_in <= '0;
    repeat (3) @(posedge clk_in);
    n_checks++;
    if (q.size() != 0) begin
      $display("BAD pending returns exp 0 got %0d", q.size());
      fail_count++;
    end
    give_verdict;
  end
endmodule : test_return_instruction_unit
`default_nettype wire
